// ### psr_pkg.sv
`default_nettype none
package psr_pkg;
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned NUM_PHYS  = 8;
  localparam int unsigned NUM_VIRT  = 8;
  localparam int unsigned NUM_IN    = 16;
  localparam int unsigned BANK_WORDS = 8;
  localparam int unsigned REF_W     = 16;
  localparam int unsigned FUNC_W    = 4;
  localparam int unsigned IRQ_W     = 4;
  localparam int unsigned CNT_W     = 4;
  localparam int unsigned DEB_W     = 10;
  // register offsets (bytes)
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] ADDR_FUNC_PHYS = 8'h10;
  localparam logic [7:0] ADDR_FUNC_VIRT = 8'h14;
  localparam logic [7:0] ADDR_VIRT_IN   = 8'h18;
  localparam logic [7:0] ADDR_AUTORST   = 8'h1c;
  localparam logic [7:0] ADDR_COMMON    = 8'h20;
  localparam logic [7:0] ADDR_KEYPAD    = 8'h24;
  localparam logic [7:0] ADDR_JOG       = 8'h28;
  localparam logic [7:0] ADDR_BANK_BASE = 8'h40;
  localparam logic [7:0] ADDR_BANK_END  = 8'hc0;
  // irq bit positions
  localparam int unsigned IRQ_BANK  = 0;
  localparam int unsigned IRQ_ARST  = 1;
  localparam int unsigned IRQ_LIMIT = 2;
  localparam int unsigned IRQ_COPY  = 3;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DEBOUNCE_NS   = 100000;
  localparam int unsigned DEB_CYC = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYC - 1);

  typedef enum logic [1:0] {
    BSRC_PANEL, BSRC_SERIAL, BSRC_DIGITAL
  } psr_bank_src_e;
  typedef enum logic [1:0] {
    REF_REMOTE, REF_KEYPAD, REF_SERIAL, REF_OPTION
  } psr_ref_sel_e;
  typedef enum logic [3:0] {
    F_NONE, F_BANK0, F_BANK1, F_PRESET0, F_PRESET1, F_PRESET2,
    F_JOG, F_RESET
  } psr_func_e;

  typedef struct packed {
    logic [19:0]   rsvd;
    logic [1:0]    copy_dst;
    logic [1:0]    copy_src;
    logic          copy_go;
    logic          cnt_clr;
    psr_ref_sel_e  ref_sel;
    logic [1:0]    panel_bank;
    psr_bank_src_e bank_src;
  } psr_ctrl_s;
  typedef struct packed {
    logic [26:0]      rsvd;
    logic             en;
    logic [CNT_W-1:0] max;
  } psr_arst_s;
  typedef struct packed {
    logic [24:0]      rsvd;
    logic             limit;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       bank;
  } psr_stat_s;

  localparam psr_ctrl_s CTRL_RST = '0;
  localparam psr_arst_s ARST_RST = '{rsvd: '0, en: 1'b0, max: 4'h3};
  localparam logic [15:0] COMMON_RST = 16'h0000;
endpackage : psr_pkg
`default_nettype wire

// ### psr_select.sv
`default_nettype none
module psr_select (
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         rstn_in,
  // avalon-mm slave
  input  wire logic [7:0]   avs_address_in,
  input  wire logic         avs_read_in,
  input  wire logic         avs_write_in,
  input  wire logic [31:0]  avs_writedata_in,
  input  wire logic [3:0]   avs_byteenable_in,
  output logic      [31:0]  avs_readdata_out,
  output logic              avs_waitrequest_out,
  // digital control inputs
  input  wire logic [7:0]   digital_control_input_in,
  // alternative sources
  input  wire logic [1:0]   serial_bank_in,
  input  wire logic [15:0]  serial_ref_in,
  input  wire logic [15:0]  option_ref_in,
  input  wire logic [15:0]  analog_ref_in,
  input  wire logic [15:0]  motor_potentiometer_reference_in,
  input  wire logic         motor_potentiometer_active_in,
  // fault status
  input  wire logic         fault_in,
  input  wire logic         fault_autoreset_ok_in,
  // outputs
  output logic      [1:0]   active_bank_out,
  output logic      [15:0]  speed_ref_out,
  output logic      [15:0]  common_cfg_out,
  output logic              fault_reset_out,
  output logic              restart_limit_reached_out,
  output logic              irq_out
);
  localparam int unsigned NI = psr_pkg::NUM_IN;
  localparam int unsigned FW = psr_pkg::FUNC_W;

  function automatic logic func_hit(
    input logic [NI*FW-1:0] map,
    input logic [NI-1:0]    lv,
    input psr_pkg::psr_func_e f
  );
    logic r;
    r = 1'b0;
    for (int i = 0; i < NI; i++) begin
      if (map[i*FW +: FW] == f && lv[i]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : func_hit

  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // registers
  psr_pkg::psr_ctrl_s        ctrl_q;
  psr_pkg::psr_arst_s        arst_q;
  logic [psr_pkg::IRQ_W-1:0] irq_stat_q;
  logic [psr_pkg::IRQ_W-1:0] irq_mask_q;
  logic [31:0]               func_phys_q;
  logic [31:0]               func_virt_q;
  logic [7:0]                virt_q;
  logic [15:0]               common_q;
  logic [15:0]               keypad_q;
  logic [15:0]               jog_q;
  logic [15:0]               bank_mem [psr_pkg::NUM_BANKS]
                                      [psr_pkg::BANK_WORDS];
  logic                      wait_q;
  logic [31:0]               rdata_q;
  logic [1:0]                bank_q;
  logic [15:0]               speed_q;
  logic                      rst_pulse_q;
  logic                      limit_q;
  logic                      pend_q;
  logic                      fault_q;
  logic [psr_pkg::CNT_W-1:0] cnt_q;
  logic                      irq_q;
  logic [7:0]                sync1_q;
  logic [7:0]                sync2_q;
  logic [7:0]                deb_w;

  // input synchronise and debounce
  // first stage feeds only the second, never the decode
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= digital_control_input_in;
      sync2_q <= sync1_q;
    end
  end

  for (genvar g = 0; g < psr_pkg::NUM_PHYS; g++) begin : g_deb
    logic [psr_pkg::DEB_W-1:0] cnt_d_q;
    logic                      deb_q;
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        cnt_d_q <= '0;
        deb_q   <= 1'b0;
      end else if (sync2_q[g] == deb_q) begin
        cnt_d_q <= '0;
      end else if (cnt_d_q == psr_pkg::DEB_LAST) begin
        cnt_d_q <= '0;
        deb_q   <= sync2_q[g];
      end else begin
        cnt_d_q <= cnt_d_q + 1'b1;
      end
    end
    assign deb_w[g] = deb_q;
  end

  // function decode
  wire [NI-1:0]    in_all  = {virt_q, deb_w};
  wire [NI*FW-1:0] fmap    = {func_virt_q, func_phys_q};
  wire [1:0] bank_dig = {
    func_hit(fmap, in_all, psr_pkg::F_BANK1),
    func_hit(fmap, in_all, psr_pkg::F_BANK0)};
  wire [2:0] preset_code = {
    func_hit(fmap, in_all, psr_pkg::F_PRESET2),
    func_hit(fmap, in_all, psr_pkg::F_PRESET1),
    func_hit(fmap, in_all, psr_pkg::F_PRESET0)};
  wire [2:0] preset_used = {
    func_hit(fmap, '1, psr_pkg::F_PRESET2),
    func_hit(fmap, '1, psr_pkg::F_PRESET1),
    func_hit(fmap, '1, psr_pkg::F_PRESET0)};
  wire jog_act   = func_hit(fmap, in_all, psr_pkg::F_JOG);
  wire rst_held  = func_hit(fmap, in_all, psr_pkg::F_RESET);

  // bank selection
  wire [1:0] bank_sel =
    (ctrl_q.bank_src == psr_pkg::BSRC_DIGITAL) ? bank_dig :
    (ctrl_q.bank_src == psr_pkg::BSRC_SERIAL) ? serial_bank_in :
    ctrl_q.panel_bank;
  wire bank_chg = (bank_sel != bank_q);

  // reference priority
  wire [15:0] preset_ref = bank_mem[bank_q][preset_code];
  wire [15:0] remote_ref =
    (|preset_used) ? preset_ref :
    motor_potentiometer_active_in ? motor_potentiometer_reference_in :
    analog_ref_in;
  wire [15:0] sel_ref =
    (ctrl_q.ref_sel == psr_pkg::REF_REMOTE) ? remote_ref :
    (ctrl_q.ref_sel == psr_pkg::REF_KEYPAD) ? keypad_q :
    (ctrl_q.ref_sel == psr_pkg::REF_SERIAL) ? serial_ref_in :
    option_ref_in;
  wire [15:0] ref_next = jog_act ? jog_q : sel_ref;

  // automatic fault reset
  wire arst_room = (cnt_q < arst_q.max);
  wire arst_ok   = fault_in & fault_autoreset_ok_in & arst_q.en & pend_q;
  wire arst_fire = arst_ok & rst_held & arst_room & ~rst_pulse_q;
  wire limit_hit = arst_ok & ~arst_room;

  // bus decode
  wire       acc    = (avs_read_in | avs_write_in) & ~wait_q;
  wire       wr     = avs_write_in & ~wait_q;
  wire [7:0] a      = avs_address_in;
  wire [7:0] boff   = a - psr_pkg::ADDR_BANK_BASE;
  wire       bank_a = (a >= psr_pkg::ADDR_BANK_BASE) &&
                      (a < psr_pkg::ADDR_BANK_END) && (a[1:0] == 2'b00);
  wire [1:0] b_idx  = boff[6:5];
  wire [2:0] w_idx  = boff[4:2];
  wire [31:0] wd    = avs_writedata_in;
  wire [3:0]  be    = avs_byteenable_in;
  wire wr_ctrl = wr && (a == psr_pkg::ADDR_CTRL);
  wire wr_stat = wr && (a == psr_pkg::ADDR_IRQ_STAT);
  psr_pkg::psr_ctrl_s ctrl_wd;
  assign ctrl_wd = psr_pkg::psr_ctrl_s'(be_merge(ctrl_q, wd, be));
  wire do_copy = wr_ctrl & ctrl_wd.copy_go;
  wire do_clr  = wr_ctrl & ctrl_wd.cnt_clr;

  psr_pkg::psr_stat_s stat_w;
  assign stat_w = '{rsvd: '0, limit: limit_q, cnt: cnt_q, bank: bank_q};
  wire [31:0] rd_mux =
    (a == psr_pkg::ADDR_CTRL)      ? 32'(ctrl_q) :
    (a == psr_pkg::ADDR_STATUS)    ? 32'(stat_w) :
    (a == psr_pkg::ADDR_IRQ_STAT)  ? {28'h0, irq_stat_q} :
    (a == psr_pkg::ADDR_IRQ_MASK)  ? {28'h0, irq_mask_q} :
    (a == psr_pkg::ADDR_FUNC_PHYS) ? func_phys_q :
    (a == psr_pkg::ADDR_FUNC_VIRT) ? func_virt_q :
    (a == psr_pkg::ADDR_VIRT_IN)   ? {24'h0, virt_q} :
    (a == psr_pkg::ADDR_AUTORST)   ? 32'(arst_q) :
    (a == psr_pkg::ADDR_COMMON)    ? {16'h0, common_q} :
    (a == psr_pkg::ADDR_KEYPAD)    ? {16'h0, keypad_q} :
    (a == psr_pkg::ADDR_JOG)       ? {16'h0, jog_q} :
    bank_a ? {16'h0, bank_mem[b_idx][w_idx]} : 32'h0000_0000;

  wire [psr_pkg::IRQ_W-1:0] ev = {do_copy, limit_hit & ~limit_q,
                                  arst_fire, bank_chg};
  // write one to clear, lane enables respected
  wire [31:0] w1c_full = be_merge(32'h0, wd, be);
  wire [psr_pkg::IRQ_W-1:0] w1c =
    wr_stat ? w1c_full[psr_pkg::IRQ_W-1:0] : '0;

  // bus handshake: one wait cycle, then access
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
      if (avs_read_in & wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q      <= psr_pkg::CTRL_RST;
      arst_q      <= psr_pkg::ARST_RST;
      irq_mask_q  <= '0;
      func_phys_q <= '0;
      func_virt_q <= '0;
      virt_q      <= '0;
      common_q    <= psr_pkg::COMMON_RST;
      keypad_q    <= '0;
      jog_q       <= '0;
    end else if (wr) begin
      unique case (a)
        psr_pkg::ADDR_CTRL: begin
          ctrl_q         <= ctrl_wd;
          ctrl_q.copy_go <= 1'b0;
          ctrl_q.cnt_clr <= 1'b0;
          ctrl_q.rsvd    <= '0;
        end
        // narrow registers keep only their low lanes
        psr_pkg::ADDR_IRQ_MASK:
          irq_mask_q <= 4'(be_merge({28'h0, irq_mask_q}, wd, be));
        psr_pkg::ADDR_FUNC_PHYS:
          func_phys_q <= be_merge(func_phys_q, wd, be);
        psr_pkg::ADDR_FUNC_VIRT:
          func_virt_q <= be_merge(func_virt_q, wd, be);
        psr_pkg::ADDR_VIRT_IN:
          virt_q <= 8'(be_merge({24'h0, virt_q}, wd, be));
        psr_pkg::ADDR_AUTORST: begin
          arst_q      <= psr_pkg::psr_arst_s'(be_merge(arst_q, wd, be));
          arst_q.rsvd <= '0;
        end
        psr_pkg::ADDR_COMMON:
          common_q <= 16'(be_merge({16'h0, common_q}, wd, be));
        psr_pkg::ADDR_KEYPAD:
          keypad_q <= 16'(be_merge({16'h0, keypad_q}, wd, be));
        psr_pkg::ADDR_JOG:
          jog_q <= 16'(be_merge({16'h0, jog_q}, wd, be));
        // unmapped and read-only offsets ignore writes
        default: ;
      endcase
    end
  end

  // bank parameter memory with copy
  // copy and a bank write never share one access edge
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bank_mem <= '{default: '{default: 16'h0000}};
    end else if (do_copy) begin
      for (int w = 0; w < psr_pkg::BANK_WORDS; w++) begin
        bank_mem[ctrl_wd.copy_dst][w] <=
          bank_mem[ctrl_wd.copy_src][w];
      end
    end else if (wr && bank_a) begin
      bank_mem[b_idx][w_idx] <=
        16'(be_merge({16'h0, bank_mem[b_idx][w_idx]}, wd, be));
    end
  end

  // active bank and reference
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bank_q  <= 2'b00;
      speed_q <= '0;
    end else begin
      bank_q  <= bank_sel;
      speed_q <= ref_next;
    end
  end

  // automatic reset counter
  // one reset per fault rising edge; limit stays until cleared
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_q     <= 1'b0;
      pend_q      <= 1'b0;
      rst_pulse_q <= 1'b0;
      cnt_q       <= '0;
      limit_q     <= 1'b0;
    end else begin
      fault_q     <= fault_in;
      rst_pulse_q <= arst_fire;
      if (!fault_in || arst_fire) begin
        pend_q <= 1'b0;
      end else if (!fault_q) begin
        pend_q <= 1'b1;
      end
      if (do_clr) begin
        cnt_q   <= '0;
        limit_q <= 1'b0;
      end else begin
        if (arst_fire) begin
          cnt_q <= cnt_q + 1'b1;
        end
        if (limit_hit) begin
          limit_q <= 1'b1;
        end
      end
    end
  end

  // interrupts: set wins over clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign avs_readdata_out          = rdata_q;
  assign avs_waitrequest_out       = wait_q;
  assign active_bank_out           = bank_q;
  assign speed_ref_out             = speed_q;
  assign common_cfg_out            = common_q;
  assign fault_reset_out           = rst_pulse_q;
  assign restart_limit_reached_out = limit_q;
  assign irq_out                   = irq_q;
endmodule : psr_select
`default_nettype wire

// ### psr_select_assertions.sv
`default_nettype none
module psr_select_assertions (
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  // register bus
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // fault and selection
  input wire logic        fault_in,
  input wire logic        fault_autoreset_ok_in,
  input wire logic [1:0]  active_bank_out,
  input wire logic        fault_reset_out,
  input wire logic        restart_limit_reached_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic clr_wr;
  assign clr_wr = avs_write_in && avs_writedata_in[6] &&
                  (avs_address_in == psr_pkg::ADDR_CTRL);
  a_wait_answer: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer");
  a_wait_one_low: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("waitrequest low too long");
  a_data_stands: assert property (!(avs_read_in && avs_waitrequest_out) |=>
    $stable(avs_readdata_out)) else $error("readdata moved");
  a_bank_after_reset: assert property ($rose(rstn_in) |->
    active_bank_out == 2'h0) else $error("bank not a after reset");
  a_pulse_single: assert property (fault_reset_out |=>
    !fault_reset_out) else $error("reset pulse too long");
  a_pulse_cause: assert property (fault_reset_out |->
    $past(fault_in) && $past(fault_autoreset_ok_in))
    else $error("reset pulse without fault");
  a_limit_blocks: assert property (restart_limit_reached_out |->
    !fault_reset_out) else $error("reset issued past limit");
  a_limit_sticky: assert property (restart_limit_reached_out &&
    !clr_wr && !$past(clr_wr) |=> restart_limit_reached_out)
    else $error("limit dropped");
  a_limit_cause: assert property ($rose(restart_limit_reached_out) |->
    $past(fault_in) && $past(fault_autoreset_ok_in))
    else $error("limit without fault");
endmodule : psr_select_assertions
`default_nettype wire

// ### psr_plc_model.sv
`default_nettype none
module psr_plc_model (
  // clock
  input  wire logic       ref_clk_in,
  // wanted switch levels
  input  wire logic [7:0] level_in,
  // drive to the control inputs
  output logic      [7:0] digital_control_input_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial digital_control_input_out = 8'h00;
  // levels held steady; the reset input stays on, never pulsed
  always @(posedge ref_clk_in) begin
    digital_control_input_out <= level_in;
  end
endmodule : psr_plc_model
`default_nettype wire

// ### testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [7:0]  avs_address_in = 8'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [7:0]  digital_control_input_in;
  logic [7:0]  plc_level = 8'h00;
  logic [1:0]  serial_bank_in = 2'h0;
  logic [15:0] serial_ref_in = 16'h2222;
  logic [15:0] option_ref_in = 16'h3333;
  logic [15:0] analog_ref_in = 16'h4444;
  logic [15:0] motor_potentiometer_reference_in = 16'h5555;
  logic        motor_potentiometer_active_in = 1'b0;
  logic        fault_in = 1'b0;
  logic        fault_autoreset_ok_in = 1'b0;
  logic [1:0]  active_bank_out;
  logic [15:0] speed_ref_out;
  logic [15:0] common_cfg_out;
  logic        fault_reset_out;
  logic        restart_limit_reached_out;
  logic        irq_out;
  logic [31:0] rd;
  int          mismatches = 0;
  int          tests_run = 0;
  int          pulses = 0;
  int          p0;
  psr_select i_psr_select (.*);
  psr_plc_model i_psr_plc_model (.ref_clk_in(ref_clk_in),
    .level_in(plc_level), .digital_control_input_out(digital_control_input_in));
  always #50 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (fault_reset_out === 1'b1) pulses++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    rd = avs_readdata_out;
    chk(32'(avs_waitrequest_out), 32'h0);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rc
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : tick
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    tick(4);
    rstn_in <= 1'b1;
    tick(2);
    chk(32'(active_bank_out), 32'h0);
    rc(psr_pkg::ADDR_AUTORST, 32'h3);
    rc(8'h30, 32'h0);
    wr(psr_pkg::ADDR_COMMON, 32'h1234);
    wr(psr_pkg::ADDR_FUNC_VIRT, 32'h0065_4321);
    wr(psr_pkg::ADDR_FUNC_PHYS, 32'h7000_0001);
    wr(psr_pkg::ADDR_VIRT_IN, 32'h3);
    wr(psr_pkg::ADDR_CTRL, 32'h8);
    tick(3);
    chk(32'(active_bank_out), 32'h2);
    serial_bank_in <= 2'h1;
    wr(psr_pkg::ADDR_CTRL, 32'h1);
    tick(3);
    chk(32'(active_bank_out), 32'h1);
    wr(psr_pkg::ADDR_CTRL, 32'h2);
    for (int c = 3; c >= 0; c--) begin
      wr(psr_pkg::ADDR_VIRT_IN, 32'(c));
      tick(2);
      chk(32'(active_bank_out), 32'(c));
    end
    plc_level <= 8'h01;
    tick(200);
    chk(32'(active_bank_out), 32'h0);
    tick(1000);
    chk(32'(active_bank_out), 32'h1);
    plc_level <= 8'h80;
    tick(1100);
    chk(32'(active_bank_out), 32'h0);
    for (int w = 0; w < 8; w++) wr(8'h40 + 8'(4 * w), 32'h1000 + 32'(w));
    for (int k = 0; k < 8; k++) begin
      wr(psr_pkg::ADDR_VIRT_IN, 32'(k << 2));
      tick(3);
      chk(32'(speed_ref_out), 32'h1000 + 32'(k));
    end
    wr(psr_pkg::ADDR_JOG, 32'h0abc);
    wr(psr_pkg::ADDR_VIRT_IN, 32'h2c);
    tick(3);
    chk(32'(speed_ref_out), 32'h0abc);
    wr(psr_pkg::ADDR_CTRL, 32'h0c82);
    for (int w = 0; w < 8; w++) rc(8'ha0 + 8'(4 * w), 32'h1000 + 32'(w));
    rc(8'h41, 32'h0);
    chk(32'(irq_out), 32'h0);
    wr(psr_pkg::ADDR_IRQ_MASK, 32'h8);
    tick(3);
    chk(32'(irq_out), 32'h1);
    wr(psr_pkg::ADDR_IRQ_STAT, 32'h8);
    tick(3);
    chk(32'(irq_out), 32'h0);
    wr(psr_pkg::ADDR_FUNC_VIRT, 32'h0060_0021);
    wr(psr_pkg::ADDR_VIRT_IN, 32'h0);
    motor_potentiometer_active_in <= 1'b1;
    tick(3);
    chk(32'(speed_ref_out), 32'h5555);
    motor_potentiometer_active_in <= 1'b0;
    tick(3);
    chk(32'(speed_ref_out), 32'h4444);
    wr(psr_pkg::ADDR_KEYPAD, 32'h0111);
    for (int s = 1; s < 4; s++) begin
      wr(psr_pkg::ADDR_CTRL, 32'h2 | 32'(s << 4));
      tick(3);
      chk(32'(speed_ref_out), s == 1 ? 32'h0111 :
          s == 2 ? 32'h2222 : 32'h3333);
    end
    wr(psr_pkg::ADDR_AUTORST, 32'h12);
    fault_autoreset_ok_in <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      p0 = pulses;
      fault_in <= 1'b1;
      tick(10);
      chk(32'(pulses - p0), 32'(i < 2));
      fault_in <= 1'b0;
      tick(5);
    end
    chk(32'(restart_limit_reached_out), 32'h1);
    rc(psr_pkg::ADDR_STATUS, 32'h48);
    wr(psr_pkg::ADDR_CTRL, 32'h42);
    tick(3);
    chk(32'(restart_limit_reached_out), 32'h0);
    chk(32'(common_cfg_out), 32'h1234);
    tally_and_finish();
  end
endmodule : testbench
bind psr_select psr_select_assertions i_psr_select_assertions (.*);
`default_nettype wire
